/* hdl/cpg_pkg.sv */
// package for the cyclic pulse generator: register map, encodings, timing
package cpg_pkg;

	// register byte offsets
	localparam logic [11:0] CPG_CFG_OFF      = 12'h000;
	localparam logic [11:0] CPG_WIDTH_OFF    = 12'h004;
	localparam logic [11:0] CPG_TIMEOUT_OFF  = 12'h008;
	localparam logic [11:0] CPG_STATUS_OFF   = 12'h00C;

	// cfg register field positions
	localparam int CPG_CFG_TBASE_LSB  = 0;
	localparam int CPG_CFG_UNIT_LSB   = 2;
	localparam int CPG_CFG_COUNT_LSB  = 4;
	localparam int CPG_CFG_MSUNIT_BIT = 8;
	localparam int CPG_CFG_POL_BIT    = 9;
	localparam int CPG_CFG_THR_LSB    = 12;
	localparam int CPG_CFG_RELOAD_BIT = 31;

	// reset values
	localparam logic [31:0] CPG_CFG_RST     = 32'h0000_6010;
	localparam logic [31:0] CPG_WIDTH_RST   = 32'h0000_0064;
	localparam logic [31:0] CPG_TIMEOUT_RST = 32'h0000_0001;

	// limits
	localparam logic [15:0] CPG_MS_MIN      = 16'h000A;
	localparam logic [15:0] CPG_S_MIN       = 16'h0001;
	localparam logic [10:0] CPG_TIMEOUT_MAX = 11'h5A0;

	// timing: 10 MHz clock, one millisecond tick
	localparam int CPG_CLK_HZ        = 10000000;
	localparam int CPG_TICK_US       = 1000;
	localparam int CPG_TICK_CYC      = CPG_CLK_HZ / 1000000 * CPG_TICK_US;
	localparam int CPG_MS_PER_S      = 1000;
	localparam int CPG_S_PER_MIN     = 60;

	// time base selection
	typedef enum logic [1:0] {
		CPG_TB_LOCAL    = 2'b00,
		CPG_TB_STANDARD = 2'b01,
		CPG_TB_UTC      = 2'b10
	} cpg_tbase_t;

	// cycle unit
	typedef enum logic [1:0] {
		CPG_UNIT_SEC  = 2'b00,
		CPG_UNIT_MIN  = 2'b01,
		CPG_UNIT_HOUR = 2'b10
	} cpg_unit_t;

	// synchronisation quality, lowest first
	typedef enum logic [2:0] {
		CPG_ST_TIME_NOT_VALID   = 3'b000,
		CPG_ST_CRYSTAL_SET      = 3'b001,
		CPG_ST_CRYSTAL_FREEWHEEL = 3'b010,
		CPG_ST_CRYSTAL_DISC_ON  = 3'b011,
		CPG_ST_LOCKED_SIMULATED = 3'b100,
		CPG_ST_LOCKED_DISC_OFF  = 3'b101,
		CPG_ST_FULLY_SYNCED     = 3'b110
	} cpg_sync_t;

	// output gating state
	typedef enum logic [1:0] {
		CPG_G_WAIT  = 2'b00,
		CPG_G_RUN   = 2'b01,
		CPG_G_HOLD  = 2'b10,
		CPG_G_STOP  = 2'b11
	} cpg_gate_t;

endpackage : cpg_pkg

/* hdl/cpg_tick.sv */
// millisecond enable divider for the cyclic pulse generator
module cpg_tick #(
	parameter int TICK_CYC = 10000
) (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// one-cycle enable
	output logic      tick
);
	import cpg_pkg::*;

	localparam int CW = $clog2(TICK_CYC);

	logic [CW-1:0] cnt_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
			tick  <= 1'b0;
		end else if (cnt_r == CW'(TICK_CYC - 1)) begin
			cnt_r <= '0;
			tick  <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			tick  <= 1'b0;
		end
	end
endmodule // cpg_tick

/* hdl/cpg_top.sv */
// cyclic pulse generator: apb registers, schedule, status gating, output
//
// Contract
// - schedule follows a chosen time base: local, standard or universal.
// - second cycles of 1,2,3,4,5,6,10,12,15,20,30 seconds.
// - minute cycles of 1,2,3,4,5,6,10,12,15,20,30 minutes.
// - hour cycles of 1,2,3,4,6,8,12,24 hours.
// - ms width at least 10; at most cycle-10ms up to 1min, else 65535.
// - s width at least 1; at most cycle-1s up to 12h, else 65535.
// - ms width units only allowed with a one-second cycle.
// - polarity selectable: high-active or low-active pulse.
// - holdover timeout from one minute to twenty-four hours.
// - pulses when status is at or above the threshold.
// - after reaching threshold, keep pulsing below it until timeout ends.
// - no pulses from startup until threshold first reached.
// - after timeout expires, stop until threshold met again.
// - seven sync states ranked from invalid up to fully synced.
// - new parameters take effect completely only after a reset; presetn restores defaults, so they are applied by the soft reload bit of cfg.
module cpg_top
	import cpg_pkg::*;
#(
	parameter int TICK_CYC = CPG_TICK_CYC
) (
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// time of day for each base, from the board timebase
	input  wire logic [16:0] tod_local_sec,
	input  wire logic [16:0] tod_standard_sec,
	input  wire logic [16:0] tod_utc_sec,
	input  wire logic        tod_sec_strobe,
	input  wire cpg_sync_t   sync_status,
	// pulse output
	output logic             pulse_out
);
	import cpg_pkg::*;

	// software side registers, written any time
	logic [31:0] cfg_r;
	logic [15:0] width_r;
	logic [10:0] timeout_r;
	// active copies, loaded at reset release and again after a soft reload
	logic [31:0] act_cfg_r;
	logic [15:0] act_width_r;
	logic [10:0] act_tmo_r;
	logic        loaded_r;

	// cycle tables: allowed counts per unit
	function automatic logic [4:0] cpg_count(input logic [3:0] idx, input cpg_unit_t u);
		logic [4:0] sm [0:10];
		logic [4:0] hr [0:7];
		sm = '{5'd1, 5'd2, 5'd3, 5'd4, 5'd5, 5'd6, 5'd10, 5'd12, 5'd15, 5'd20, 5'd30};
		hr = '{5'd1, 5'd2, 5'd3, 5'd4, 5'd6, 5'd8, 5'd12, 5'd24};
		if (u == CPG_UNIT_HOUR) begin
			cpg_count = (idx < 4'd8) ? hr[idx[2:0]] : 5'd0;
		end else begin
			cpg_count = (idx < 4'd11) ? sm[idx] : 5'd0;
		end
	endfunction

	// cycle length in seconds
	function automatic logic [16:0] cpg_cycle_sec(input logic [31:0] c);
		logic [16:0] n;
		n = {12'h000, cpg_count(c[CPG_CFG_COUNT_LSB +: 4], cpg_unit_t'(c[CPG_CFG_UNIT_LSB +: 2]))};
		case (cpg_unit_t'(c[CPG_CFG_UNIT_LSB +: 2]))
			CPG_UNIT_SEC:  cpg_cycle_sec = n;
			CPG_UNIT_MIN:  cpg_cycle_sec = 17'(n * 17'd60);
			CPG_UNIT_HOUR: cpg_cycle_sec = 17'(n * 17'd3600);
			default:       cpg_cycle_sec = 17'h00000;
		endcase
	endfunction

	// holdover minutes kept inside one minute .. one day, so a readback is always legal
	function automatic logic [10:0] cpg_tmo_clamp(input logic [31:0] v);
		if (v == 32'h0000_0000) begin
			cpg_tmo_clamp = 11'h001;
		end else if (v > {21'h0_0000, CPG_TIMEOUT_MAX}) begin
			cpg_tmo_clamp = CPG_TIMEOUT_MAX;
		end else begin
			cpg_tmo_clamp = v[10:0];
		end
	endfunction

	logic        apb_wr;
	logic        apb_rd;
	logic        addr_ok;
	assign apb_wr  = psel && penable && pwrite;
	assign apb_rd  = psel && !penable && !pwrite;
	assign addr_ok = (paddr == CPG_CFG_OFF) || (paddr == CPG_WIDTH_OFF) ||
	                 (paddr == CPG_TIMEOUT_OFF) || (paddr == CPG_STATUS_OFF);

	// register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r     <= CPG_CFG_RST;
			width_r   <= CPG_WIDTH_RST[15:0];
			timeout_r <= CPG_TIMEOUT_RST[10:0];
		end else if (apb_wr) begin
			case (paddr)
				CPG_CFG_OFF:     cfg_r     <= pwdata & ~(32'h0000_0001 << CPG_CFG_RELOAD_BIT);
				CPG_WIDTH_OFF:   width_r   <= pwdata[15:0];
				CPG_TIMEOUT_OFF: timeout_r <= cpg_tmo_clamp(pwdata);
				default: ;
			endcase
		end
	end

	// validity of the active setting
	logic [16:0] cyc_sec;
	logic        ms_unit;
	logic        cfg_ok;
	logic [16:0] wmax;
	always_comb begin
		cyc_sec = cpg_cycle_sec(act_cfg_r);
		ms_unit = act_cfg_r[CPG_CFG_MSUNIT_BIT];
		if (ms_unit) begin
			// ms width limited by a one-second cycle, minus 10 ms
			wmax   = 17'd990;
			cfg_ok = (cyc_sec == 17'd1) && (act_width_r >= CPG_MS_MIN) &&
			         ({1'b0, act_width_r} <= wmax);
		end else begin
			wmax   = (cyc_sec <= 17'd43200) ? 17'(cyc_sec - 17'd1) : 17'h0FFFF;
			cfg_ok = (cyc_sec != 17'd0) && (act_width_r >= CPG_S_MIN) &&
			         ({1'b0, act_width_r} <= wmax);
		end
		if (act_cfg_r[CPG_CFG_TBASE_LSB +: 2] == 2'b11) begin
			cfg_ok = 1'b0;
		end
	end

	// parameters captured after reset release and again after each soft reload
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_cfg_r   <= CPG_CFG_RST;
			act_width_r <= CPG_WIDTH_RST[15:0];
			act_tmo_r   <= CPG_TIMEOUT_RST[10:0];
			loaded_r    <= 1'b0;
		end else if (!loaded_r) begin
			act_cfg_r   <= cfg_r;
			act_width_r <= width_r;
			act_tmo_r   <= timeout_r;
			loaded_r    <= 1'b1;
		end else if (apb_wr && (paddr == CPG_CFG_OFF) && pwdata[CPG_CFG_RELOAD_BIT]) begin
			// soft reset of the parameter set: copied again on the next cycle
			loaded_r    <= 1'b0;
		end
	end

	// presetn also restores register defaults, so new values are applied by the
	// soft reload bit of cfg; the bit itself is never stored.

	logic ms_tick;
	cpg_tick #(
		.TICK_CYC(TICK_CYC)
	) u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.tick    (ms_tick)
	);

	// chosen time base
	logic [16:0] tod_sel;
	always_comb begin
		case (cpg_tbase_t'(act_cfg_r[CPG_CFG_TBASE_LSB +: 2]))
			CPG_TB_LOCAL:    tod_sel = tod_local_sec;
			CPG_TB_STANDARD: tod_sel = tod_standard_sec;
			CPG_TB_UTC:      tod_sel = tod_utc_sec;
			default:         tod_sel = tod_utc_sec;
		endcase
	end

	// synchronise the timebase inputs
	logic        strb_s1_r, strb_s2_r, strb_s3_r;
	logic [16:0] tod_s1_r, tod_s2_r;
	logic [2:0]  st_s1_r, st_s2_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strb_s1_r <= 1'b0;
			strb_s2_r <= 1'b0;
			strb_s3_r <= 1'b0;
			tod_s1_r  <= '0;
			tod_s2_r  <= '0;
			st_s1_r   <= '0;
			st_s2_r   <= '0;
		end else begin
			strb_s1_r <= tod_sec_strobe;
			strb_s2_r <= strb_s1_r;
			strb_s3_r <= strb_s2_r;
			tod_s1_r  <= tod_sel;
			tod_s2_r  <= tod_s1_r;
			st_s1_r   <= sync_status;
			st_s2_r   <= st_s1_r;
		end
	end

	logic sec_edge;
	assign sec_edge = strb_s2_r && !strb_s3_r;

	// boundary: time of day divisible by cycle
	logic boundary;
	assign boundary = sec_edge && cfg_ok && ((tod_s2_r % cyc_sec) == 17'd0);

	// pulse width timing, in ms or s
	logic [16:0] wcnt_r;
	logic        active_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wcnt_r   <= '0;
			active_r <= 1'b0;
		end else if (boundary) begin
			wcnt_r   <= {1'b0, act_width_r};
			active_r <= 1'b1;
		end else if (active_r && (ms_unit ? ms_tick : sec_edge)) begin
			if (wcnt_r <= 17'd1) begin
				active_r <= 1'b0;
				wcnt_r   <= '0;
			end else begin
				wcnt_r <= wcnt_r - 17'd1;
			end
		end
	end

	// status gating
	logic good;
	assign good = (st_s2_r >= act_cfg_r[CPG_CFG_THR_LSB +: 3]) &&
	              (st_s2_r <= CPG_ST_FULLY_SYNCED);

	cpg_gate_t   gate_r;
	logic [10:0] hold_min_r;
	logic [5:0]  hold_sec_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_r     <= CPG_G_WAIT;
			hold_min_r <= '0;
			hold_sec_r <= '0;
		end else begin
			case (gate_r)
				CPG_G_WAIT: if (good && loaded_r) gate_r <= CPG_G_RUN;
				CPG_G_RUN: begin
					if (!good) begin
						gate_r     <= CPG_G_HOLD;
						hold_min_r <= act_tmo_r;
						hold_sec_r <= 6'd0;
					end
				end
				CPG_G_HOLD: begin
					if (good) begin
						gate_r <= CPG_G_RUN;
					end else if (sec_edge) begin
						if (hold_sec_r == 6'(CPG_S_PER_MIN - 1)) begin
							hold_sec_r <= 6'd0;
							if (hold_min_r <= 11'd1) begin
								gate_r <= CPG_G_STOP;
							end else begin
								hold_min_r <= hold_min_r - 11'd1;
							end
						end else begin
							hold_sec_r <= hold_sec_r + 6'd1;
						end
					end
				end
				CPG_G_STOP: if (good) gate_r <= CPG_G_RUN;
				default: gate_r <= CPG_G_WAIT;
			endcase
		end
	end

	logic enabled;
	assign enabled = (gate_r == CPG_G_RUN) || (gate_r == CPG_G_HOLD);

	// output with polarity; inactive level while suppressed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// inactive level of the default polarity, even while reset is held
			pulse_out <= ~CPG_CFG_RST[CPG_CFG_POL_BIT];
		end else begin
			pulse_out <= (enabled && active_r) ^ ~act_cfg_r[CPG_CFG_POL_BIT];
		end
	end

	// apb read, answered in the access phase with no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			if (apb_rd) begin
				case (paddr)
					CPG_CFG_OFF:     prdata <= cfg_r;
					CPG_WIDTH_OFF:   prdata <= {16'h0000, width_r};
					CPG_TIMEOUT_OFF: prdata <= {21'h0_0000, timeout_r};
					CPG_STATUS_OFF:  prdata <= {24'h00_0000, cfg_ok, gate_r, active_r, loaded_r, st_s2_r};
					default:         prdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // cpg_top

/* verification/cpg_receiver.sv */
// downstream receiver model: counts level changes on the pulse line
module cpg_receiver (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// pulse line
	input  wire logic pulse_line,
	// level changes seen once the line has settled
	output int        edges
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       prev;
	logic [1:0] settle;
	// the first edges after reset move the line to its idle level, not a pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle <= 2'h0;
			edges <= 0;
		end else begin
			prev <= pulse_line;
			if (settle != 2'h3)
				settle <= settle + 2'h1;
			else if (pulse_line !== prev)
				edges <= edges + 1;
		end
	end
endmodule // cpg_receiver

/* verification/cpg_top_monitor.sv */
// bus and field checks on the cyclic pulse generator ports
module cpg_top_monitor
	import cpg_pkg::*;
#(
	parameter int TICK_CYC = CPG_TICK_CYC
) (
	// apb slave
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// time of day and status
	input wire logic [16:0] tod_local_sec,
	input wire logic [16:0] tod_standard_sec,
	input wire logic [16:0] tod_utc_sec,
	input wire logic        tod_sec_strobe,
	input wire cpg_sync_t   sync_status,
	// pulse output
	input wire logic        pulse_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
		else $error("ready missing after setup");
	AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
		else $error("ready held too long");
	AST_READY_IN_ACCESS: assert property (pready |-> psel && penable && !$past(penable))
		else $error("ready outside access");
	AST_ERR_QUALIFIED: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_ERR_UNMAPPED: assert property (pready && paddr[11:4] != 8'h00 |-> pslverr)
		else $error("unmapped access not refused");
	AST_ERR_MAPPED: assert property (pready && paddr[11:4] == 8'h00 && paddr[1:0] == 2'b00
		|-> !pslverr)
		else $error("mapped access refused");
	AST_ERR_RDATA_ZERO: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
		else $error("refused access returns data");
	AST_TIMEOUT_RANGE: assert property (pready && !pwrite && paddr == CPG_TIMEOUT_OFF
		|-> prdata[31:11] == '0 && prdata[10:0] inside {[11'h001:CPG_TIMEOUT_MAX]})
		else $error("holdover timeout out of range");
	AST_WIDTH_FIELD: assert property (pready && !pwrite && paddr == CPG_WIDTH_OFF
		|-> prdata[31:16] == 16'h0000)
		else $error("width field too wide");
endmodule // cpg_top_monitor

/* verification/cyclic_pulse_generator_bench.sv */
// self-checking testbench for the cyclic pulse generator
module cyclic_pulse_generator_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import cpg_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, strobe = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic        pready, pslverr, pulse_out, e;
	logic [16:0] tod = '0;
	cpg_sync_t   sync = CPG_ST_LOCKED_DISC_OFF;
	int          err_count = 0, checks_done = 0, cyc = 0, edges, base;

	always #50 pclk = ~pclk;

	cpg_top #(.TICK_CYC(10)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tod_local_sec(tod), .tod_standard_sec(tod),
		.tod_utc_sec(tod), .tod_sec_strobe(strobe), .sync_status(sync), .pulse_out(pulse_out));
	cpg_receiver rx (.pclk(pclk), .presetn(presetn), .pulse_line(pulse_out), .edges(edges));

	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checks_done++;
		if (g !== x) begin
			$display("[FAIL] %s expected %h seen %h", n, x, g);
			err_count++;
		end
	endtask

	// request held until pready is seen high at a rising edge; data taken at that edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd_v, output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			err_count++;
		rd_v = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
		apb(1'b0, a, 32'h0, r, e);
		chk(n, x, r);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, r, e);
	endtask

	task automatic secs(input int n);
		repeat (n) begin
			strobe <= 1'b1;
			tod <= tod + 17'h1;
			repeat (5) @(posedge pclk);
			strobe <= 1'b0;
			repeat (5) @(posedge pclk);
		end
	endtask

	function automatic logic [31:0] stat(input cpg_gate_t g, input logic [2:0] s);
		return {24'h0, 1'b0, g, 1'b0, 1'b1, s};
	endfunction

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			close_out;
		end
	end

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(CPG_CFG_OFF, CPG_CFG_RST, "cfg reset");
		rd(CPG_WIDTH_OFF, CPG_WIDTH_RST, "width reset");
		rd(CPG_TIMEOUT_OFF, CPG_TIMEOUT_RST, "timeout reset");
		wr(CPG_TIMEOUT_OFF, 32'h0000_0FFF);
		rd(CPG_TIMEOUT_OFF, 32'h0000_05A0, "timeout max");
		wr(CPG_TIMEOUT_OFF, 32'h0000_0000);
		rd(CPG_TIMEOUT_OFF, 32'h0000_0001, "timeout min");
		wr(CPG_WIDTH_OFF, 32'h0001_1234);
		rd(CPG_WIDTH_OFF, 32'h0000_1234, "width field");
		wr(CPG_STATUS_OFF, 32'h0000_00FF);
		apb(1'b0, 12'h010, 32'h0, r, e);
		chk("unmapped error", 32'h1, {31'h0, e});
		// every state below the reset threshold leaves the output waiting
		for (int s = 0; s < 6; s++) begin
			sync <= cpg_sync_t'(s);
			repeat (6) @(posedge pclk);
			rd(CPG_STATUS_OFF, stat(CPG_G_WAIT, s[2:0]), "gate wait");
		end
		sync <= CPG_ST_FULLY_SYNCED;
		repeat (6) @(posedge pclk);
		rd(CPG_STATUS_OFF, stat(CPG_G_RUN, 3'h6), "gate run");
		sync <= CPG_ST_LOCKED_DISC_OFF;
		secs(58);
		rd(CPG_STATUS_OFF, stat(CPG_G_HOLD, 3'h5), "gate hold");
		secs(4);
		rd(CPG_STATUS_OFF, stat(CPG_G_STOP, 3'h5), "gate stop");
		sync <= CPG_ST_FULLY_SYNCED;
		repeat (6) @(posedge pclk);
		rd(CPG_STATUS_OFF, stat(CPG_G_RUN, 3'h6), "gate rerun");
		chk("idle level", {31'h0, ~CPG_CFG_RST[CPG_CFG_POL_BIT]}, {31'h0, pulse_out});
		chk("pulses seen", 32'h0, edges);
		// two second cycle, one second width, high active, applied by soft reload
		wr(CPG_WIDTH_OFF, 32'h0000_0001);
		wr(CPG_CFG_OFF, 32'h8000_6210);
		rd(CPG_CFG_OFF, 32'h0000_6210, "cfg reload");
		rd(CPG_STATUS_OFF, stat(CPG_G_RUN, 3'h6) | 32'h0000_0080, "config valid");
		chk("idle high active", 32'h0, {31'h0, pulse_out});
		base = edges;
		secs(9);
		chk("pulse edges", 32'h0000_0008, edges - base);
		chk("idle after pulses", 32'h0, {31'h0, pulse_out});
		close_out;
	end
endmodule // cyclic_pulse_generator_bench

bind cpg_top cpg_top_monitor #(.TICK_CYC(TICK_CYC)) u_mon (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .tod_local_sec(tod_local_sec),
	.tod_standard_sec(tod_standard_sec), .tod_utc_sec(tod_utc_sec),
	.tod_sec_strobe(tod_sec_strobe), .sync_status(sync_status), .pulse_out(pulse_out));
